// *** hdl/hmsf_mailbox.sv ***
// Host mailbox with handshake flags, external state view and AXI4-Lite slave
// Behaviour
// - 32-bit mailbox built from high and low 16-bit word registers.
// - Core read of high word clears the command-in pending flag.
// - Core write of high word sets the response-out valid flag.
// - Response-out valid appears five instructions after the high word write.
// - Command-in pending clears five instructions after the high word read.
// - External state view is read-only and shows internal conditions and pins.
// - State bit 15 always reads one, for unconditional branches.
// - Bits 14 and 13 show DMA2 and DMA1 queue stage busy.
// - Bits 12 and 11 show DMA2 and DMA1 output or queue busy.
// - Bit 10 at transmit counter full, bit 2 at counter two or less.
// - Bit 9 receive counter nonzero, bit 3 receive counter four or more.
// - Bit 5 cell scheduler operation, bit 4 assigned cell flag.
// - Bits 1 and 0 show sense inputs B and A, three instructions delayed.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module hmsf_mailbox
  import hmsf_pkg::*;
#(
  parameter int         INSTR_CYCLES = 1,
  parameter int         CNT_W        = 8,
  parameter int         SPARSE_W     = 16,
  parameter logic [7:0] TX_FULL_VAL  = 8'h08
) (
  input  logic                    aclk,
  input  logic                    aresetn,
  input  logic [7:0]              s_axi_awaddr,
  input  logic                    s_axi_awvalid,
  output logic                    s_axi_awready,
  input  logic [31:0]             s_axi_wdata,
  input  logic [3:0]              s_axi_wstrb,
  input  logic                    s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  logic                    s_axi_bready,
  input  logic [7:0]              s_axi_araddr,
  input  logic                    s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  logic                    s_axi_rready,
  input  logic                    host_cmd_write,
  input  logic [31:0]             host_command_in_word,
  input  logic                    host_resp_take,
  output logic [31:0]             response_out_word,
  output logic                    resp_out_valid,
  output logic                    cmd_in_pending,
  input  hmsf_dma_busy_type       dma_busy,
  input  logic [7:0]              tx_fill_count,
  input  logic [7:0]              rx_occupancy_count,
  input  logic [SPARSE_W-1:0]     sparse_events,
  input  logic                    cell_sched_op,
  input  logic                    assigned_cell_flag,
  input  logic                    sense_input_a,
  input  logic                    sense_input_b,
  output logic                    irq
);
  localparam int FLAG_CYC = HMSF_FLAG_DELAY_INSTR * INSTR_CYCLES;
  localparam int EVT_CYC  = HMSF_EVENT_DELAY_INSTR * INSTR_CYCLES;
  // Sense path spends two cycles in the synchroniser
  localparam int CHAIN_D  = EVT_CYC - 1;
  localparam logic [CNT_W-1:0] FLAG_CNT = CNT_W'(FLAG_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  logic [15:0]               cmd_high;
  logic [15:0]               cmd_low;
  logic [CNT_W-1:0]          clr_cnt;
  logic [CNT_W-1:0]          set_cnt;
  logic [HMSF_IRQ_BITS-1:0]  irq_status;
  logic [HMSF_IRQ_BITS-1:0]  irq_mask;
  logic                      aw_got;
  logic                      w_got;
  logic [7:0]                aw_addr_q;
  logic [31:0]               w_data_q;
  logic [3:0]                w_strb_q;
  logic [1:0]                sense_s1;
  logic [1:0]                sense_s2;
  logic                      sparse_d1;
  logic                      sparse_d2;
  logic [2:0]                chain [CHAIN_D];
  logic [15:0]               ext_state_view;

  // Write channel handshakes
  logic        aw_hs;
  logic        w_hs;
  logic        aw_have;
  logic        w_have;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        next_aw_got;
  logic        next_w_got;
  logic        next_bvalid;
  logic        wr_hi;
  logic        wr_lo;
  logic        wr_stat;
  logic        wr_mask;
  logic        ar_hs;
  logic        rd_hi;
  logic        next_rvalid;

  assign aw_hs       = s_axi_awvalid & s_axi_awready;
  assign w_hs        = s_axi_wvalid & s_axi_wready;
  assign aw_have     = aw_got | aw_hs;
  assign w_have      = w_got | w_hs;
  assign do_write    = aw_have & w_have & ~s_axi_bvalid;
  assign wr_addr     = aw_got ? aw_addr_q : s_axi_awaddr;
  assign wr_data     = w_got ? w_data_q : s_axi_wdata;
  assign wr_strb     = w_got ? w_strb_q : s_axi_wstrb;
  assign next_aw_got = aw_have & ~do_write;
  assign next_w_got  = w_have & ~do_write;
  assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_hi       = do_write && wr_addr == HMSF_OFF_MBOX_HIGH;
  assign wr_lo       = do_write && wr_addr == HMSF_OFF_MBOX_LOW;
  assign wr_stat     = do_write && wr_addr == HMSF_OFF_IRQ_STAT;
  assign wr_mask     = do_write && wr_addr == HMSF_OFF_IRQ_MASK;
  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign rd_hi       = ar_hs && s_axi_araddr == HMSF_OFF_MBOX_HIGH;
  assign next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= HMSF_RESP_OKAY;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        // Read-only view and holes answer with an error, nothing stored
        s_axi_bresp <= (wr_hi | wr_lo | wr_stat | wr_mask) ? HMSF_RESP_OKAY : HMSF_RESP_SLVERR;
      end
    end
  end

  // Outbound response word, byte lanes 0 and 1 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      response_out_word <= {HMSF_MBOX_RESET, HMSF_MBOX_RESET};
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_hi && wr_strb[b]) begin
          response_out_word[16+8*b +: 8] <= wr_data[8*b +: 8];
        end
        if (wr_lo && wr_strb[b]) begin
          response_out_word[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // Inbound command word from the host
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_high <= HMSF_MBOX_RESET;
      cmd_low  <= HMSF_MBOX_RESET;
    end else if (host_cmd_write) begin
      cmd_high <= host_command_in_word[31:16];
      cmd_low  <= host_command_in_word[15:0];
    end
  end

  // Command pending: delayed clear; a new host command wins and cancels it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_in_pending <= 1'b0;
      clr_cnt        <= CNT_ZERO;
    end else begin
      if (host_cmd_write) begin
        cmd_in_pending <= 1'b1;
        clr_cnt        <= CNT_ZERO;
      end else if (rd_hi) begin
        clr_cnt <= FLAG_CNT;
      end else if (clr_cnt != CNT_ZERO) begin
        clr_cnt <= clr_cnt - CNT_ONE;
        if (clr_cnt == CNT_ONE) begin
          cmd_in_pending <= 1'b0;
        end
      end
    end
  end

  // Response valid: delayed set wins over a host take in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_out_valid <= 1'b0;
      set_cnt        <= CNT_ZERO;
    end else begin
      if (wr_hi) begin
        set_cnt <= FLAG_CNT;
      end else if (set_cnt != CNT_ZERO) begin
        set_cnt <= set_cnt - CNT_ONE;
      end
      if (set_cnt == CNT_ONE) begin
        resp_out_valid <= 1'b1;
      end else if (host_resp_take) begin
        resp_out_valid <= 1'b0;
      end
    end
  end

  // Interrupt status, write one to clear, hardware set wins
  logic [HMSF_IRQ_BITS-1:0] irq_events;
  logic [HMSF_IRQ_BITS-1:0] next_irq_status;
  always_comb begin
    irq_events                       = '0;
    irq_events[HMSF_IRQ_CMD_ARRIVED] = host_cmd_write;
    irq_events[HMSF_IRQ_RESP_TAKEN]  = host_resp_take & resp_out_valid;
    next_irq_status                  = irq_status;
    if (wr_stat && wr_strb[0]) begin
      next_irq_status = irq_status & ~wr_data[HMSF_IRQ_BITS-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= HMSF_IRQ_RESET;
      irq_mask   <= HMSF_IRQ_RESET;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask && wr_strb[0]) begin
        irq_mask <= wr_data[HMSF_IRQ_BITS-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // Sense pins are asynchronous; sparse events come from same-clock logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_s1  <= 2'h0;
      sense_s2  <= 2'h0;
      sparse_d1 <= 1'b0;
      sparse_d2 <= 1'b0;
    end else begin
      sense_s1  <= {sense_input_b, sense_input_a};
      sense_s2  <= sense_s1;
      sparse_d1 <= |sparse_events;
      sparse_d2 <= sparse_d1;
    end
  end

  // Delay chain pads both paths out to the event latency
  generate
    for (genvar i = 0; i < CHAIN_D; i++) begin : g_chain
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chain[i] <= 3'h0;
        end else if (i == 0) begin
          chain[i] <= {sparse_d2, sense_s2};
        end else begin
          chain[i] <= chain[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  always_comb begin
    ext_state_view                    = 16'h0000;
    ext_state_view[HMSF_ES_ALWAYS]    = 1'b1;
    ext_state_view[HMSF_ES_DMA2_Q]    = dma_busy.dma2_queue_busy;
    ext_state_view[HMSF_ES_DMA1_Q]    = dma_busy.dma1_queue_busy;
    ext_state_view[HMSF_ES_DMA2_OQ]   = dma_busy.dma2_out_busy | dma_busy.dma2_queue_busy;
    ext_state_view[HMSF_ES_DMA1_OQ]   = dma_busy.dma1_out_busy | dma_busy.dma1_queue_busy;
    ext_state_view[HMSF_ES_TX_FULL]   = tx_fill_count == TX_FULL_VAL;
    ext_state_view[HMSF_ES_TX_LE2]    = tx_fill_count <= 8'(HMSF_TX_LOW_MARK);
    ext_state_view[HMSF_ES_RX_NZ]     = rx_occupancy_count != 8'h00;
    ext_state_view[HMSF_ES_RX_GE4]    = rx_occupancy_count >= 8'(HMSF_RX_HIGH_MARK);
    ext_state_view[HMSF_ES_SPARSE]    = chain[CHAIN_D-1][2];
    ext_state_view[HMSF_ES_RESP_OUT]  = resp_out_valid;
    ext_state_view[HMSF_ES_CMD_IN]    = cmd_in_pending;
    ext_state_view[HMSF_ES_CELL_OP]   = cell_sched_op;
    ext_state_view[HMSF_ES_CELL_FLAG] = assigned_cell_flag;
    ext_state_view[HMSF_ES_SENSE_B]   = chain[CHAIN_D-1][1];
    ext_state_view[HMSF_ES_SENSE_A]   = chain[CHAIN_D-1][0];
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= HMSF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rresp <= HMSF_RESP_OKAY;
        case (s_axi_araddr)
          HMSF_OFF_MBOX_HIGH: s_axi_rdata <= {16'h0000, cmd_high};
          HMSF_OFF_MBOX_LOW:  s_axi_rdata <= {16'h0000, cmd_low};
          HMSF_OFF_EXT_STATE: s_axi_rdata <= {16'h0000, ext_state_view};
          HMSF_OFF_IRQ_STAT:  s_axi_rdata <= {30'h0000_0000, irq_status};
          HMSF_OFF_IRQ_MASK:  s_axi_rdata <= {30'h0000_0000, irq_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= HMSF_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Helper: host activity since the last core read or write of the high word
  logic host_cmd_seen;
  logic host_take_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_cmd_seen  <= 1'b0;
      host_take_seen <= 1'b0;
    end else begin
      host_cmd_seen  <= rd_hi ? host_cmd_write : (host_cmd_seen | host_cmd_write);
      host_take_seen <= wr_hi ? 1'b0 : (host_take_seen | host_resp_take);
    end
  end

  // Flag moves at the edge its count ends, so it is sampled one edge later
  localparam int FLAG_SEEN  = FLAG_CYC + 1;
  localparam int EVT_CYC_I  = EVT_CYC;
  // A pin level sampled at one edge is sampled in the view this many edges on
  localparam int EVT_PAST   = EVT_CYC + 1;

  sequence s_core_reads_high;
    rd_hi && !host_cmd_write;
  endsequence

  sequence s_core_writes_high;
    wr_hi;
  endsequence

  a_cmd_clear_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    s_core_reads_high |-> ##FLAG_SEEN (!cmd_in_pending || host_cmd_seen))
    else $error("command pending not cleared after flag delay");

  a_cmd_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_core_reads_high ##0 cmd_in_pending) |=> cmd_in_pending[*4])
    else $error("command pending cleared too early");

  a_resp_set_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    s_core_writes_high |-> ##FLAG_SEEN resp_out_valid)
    else $error("response valid not set after flag delay");

  a_resp_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_core_writes_high ##0 !resp_out_valid ##1 !host_take_seen)
      |-> !resp_out_valid[*3])
    else $error("response valid set too early");

  a_host_cmd_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    host_cmd_write |=> cmd_in_pending && cmd_high == $past(host_command_in_word[31:16]))
    else $error("host command did not set pending");

  a_host_take_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (host_resp_take && set_cnt != CNT_ONE) |=> !resp_out_valid)
    else $error("host take did not clear response valid");

  a_always_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == HMSF_OFF_EXT_STATE) |=> s_axi_rdata[HMSF_ES_ALWAYS])
    else $error("unconditional state bit not set");

  a_sense_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    ##EVT_PAST 1 |-> ext_state_view[HMSF_ES_SENSE_A] == $past(sense_input_a, EVT_PAST))
    else $error("sense A not visible after event delay");

  a_sparse_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    ##EVT_CYC_I 1 |-> ext_state_view[HMSF_ES_SPARSE] == $past(sparse_d1, EVT_CYC_I))
    else $error("sparse event OR not delayed as expected");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(irq_status & irq_mask) |=> irq)
    else $error("interrupt not raised for unmasked status");

  a_ro_view: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_addr == HMSF_OFF_EXT_STATE) |=> s_axi_bvalid && s_axi_bresp == HMSF_RESP_SLVERR)
    else $error("write to read-only view not refused");
endmodule : hmsf_mailbox

// *** hdl/hmsf_pkg.sv ***
// Constants and types shared by the host mailbox and state flag block
package hmsf_pkg;
  // AXI4-Lite byte offsets
  localparam logic [7:0] HMSF_OFF_MBOX_HIGH = 8'h00;
  localparam logic [7:0] HMSF_OFF_MBOX_LOW  = 8'h04;
  localparam logic [7:0] HMSF_OFF_EXT_STATE = 8'h08;
  localparam logic [7:0] HMSF_OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] HMSF_OFF_IRQ_MASK  = 8'h10;

  // AXI responses
  localparam logic [1:0] HMSF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HMSF_RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [15:0] HMSF_MBOX_RESET = 16'h0000;
  localparam logic [1:0]  HMSF_IRQ_RESET  = 2'h0;

  // Interrupt status bit positions
  localparam int HMSF_IRQ_CMD_ARRIVED = 0;
  localparam int HMSF_IRQ_RESP_TAKEN  = 1;
  localparam int HMSF_IRQ_BITS        = 2;

  // External state view bit positions
  localparam int HMSF_ES_ALWAYS    = 15;
  localparam int HMSF_ES_DMA2_Q    = 14;
  localparam int HMSF_ES_DMA1_Q    = 13;
  localparam int HMSF_ES_DMA2_OQ   = 12;
  localparam int HMSF_ES_DMA1_OQ   = 11;
  localparam int HMSF_ES_TX_FULL   = 10;
  localparam int HMSF_ES_RX_NZ     = 9;
  localparam int HMSF_ES_SPARSE    = 8;
  localparam int HMSF_ES_RESP_OUT  = 7;
  localparam int HMSF_ES_CMD_IN    = 6;
  localparam int HMSF_ES_CELL_OP   = 5;
  localparam int HMSF_ES_CELL_FLAG = 4;
  localparam int HMSF_ES_RX_GE4    = 3;
  localparam int HMSF_ES_TX_LE2    = 2;
  localparam int HMSF_ES_SENSE_B   = 1;
  localparam int HMSF_ES_SENSE_A   = 0;

  // Counter thresholds
  localparam int HMSF_TX_LOW_MARK  = 2;
  localparam int HMSF_RX_HIGH_MARK = 4;

  // Timing in core instructions
  localparam int HMSF_FLAG_DELAY_INSTR  = 5;
  localparam int HMSF_EVENT_DELAY_INSTR = 3;

  typedef struct packed {
    logic dma2_queue_busy;
    logic dma2_out_busy;
    logic dma1_queue_busy;
    logic dma1_out_busy;
  } hmsf_dma_busy_type;
endpackage : hmsf_pkg

// *** tb/hmsf_host_model.sv ***
// Behavioural model of the external host side of the mailbox
`timescale 1ns/100ps
module hmsf_host_model
  import hmsf_pkg::*;
(
  input  logic        aclk,
  input  logic        aresetn,
  input  logic        take_en,
  input  logic        resp_out_valid,
  input  logic [31:0] response_out_word,
  output logic        host_cmd_write,
  output logic [31:0] host_command_in_word,
  output logic        host_resp_take,
  output logic [31:0] last_taken
);
  initial begin
    host_cmd_write = 1'b0;
    host_command_in_word = 32'h0000_0000;
  end

  // Called just after a rising edge; word is not held once the strobe drops
  task automatic send_cmd(input logic [31:0] w);
    host_command_in_word <= w;
    host_cmd_write <= 1'b1;
    @(posedge aclk);
    host_cmd_write <= 1'b0;
    host_command_in_word <= ~w;
  endtask : send_cmd

  // One pulse per response; the flag needs a cycle to drop after the take
  always @(posedge aclk) begin
    if (!aresetn) begin
      host_resp_take <= 1'b0;
      last_taken     <= 32'h0000_0000;
    end else begin
      host_resp_take <= take_en && resp_out_valid && !host_resp_take;
      if (take_en && resp_out_valid && !host_resp_take) begin
        last_taken <= response_out_word;
      end
    end
  end
endmodule : hmsf_host_model

// *** tb/testbench.sv ***
// Self-checking testbench for the host mailbox and state flag block
`timescale 1ns/100ps
module testbench;
  import hmsf_pkg::*;
  // Stretched instruction time so the delay figures are not all one cycle
  localparam int         IC  = 2;
  localparam logic [7:0] TXF = 8'h08;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, host_cmd_write, host_resp_take;
  logic              resp_out_valid, cmd_in_pending, irq, take_en, prev_rov, prev_cip;
  logic              cell_sched_op, assigned_cell_flag, sense_input_a, sense_input_b;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, tx_fill_count, rx_occupancy_count;
  logic [31:0]       s_axi_wdata, s_axi_rdata, host_command_in_word, response_out_word;
  logic [31:0]       last_taken, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0]       sparse_events;
  hmsf_dma_busy_type dma_busy;
  int                cyc, rise_cyc, fall_cyc, hs_cyc, h, n_errors, samples_checked;
  logic [3:0]        t_dma [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [7:0]        t_tx [4] = '{8'h08, 8'h02, 8'h03, 8'h07};
  logic [7:0]        t_rx [4] = '{8'h00, 8'h03, 8'h04, 8'hFF};
  logic [15:0]       t_sp [4] = '{16'h0000, 16'h8000, 16'h0001, 16'h0000};
  logic [3:0]        t_misc [4] = '{4'h8, 4'h4, 4'h2, 4'h1};

  hmsf_mailbox #(.INSTR_CYCLES(IC), .CNT_W(8), .SPARSE_W(16), .TX_FULL_VAL(TXF)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .host_cmd_write, .host_command_in_word, .host_resp_take,
    .response_out_word, .resp_out_valid, .cmd_in_pending, .dma_busy, .tx_fill_count,
    .rx_occupancy_count, .sparse_events, .cell_sched_op, .assigned_cell_flag,
    .sense_input_a, .sense_input_b, .irq);

  hmsf_host_model i_host (.aclk, .aresetn, .take_en, .resp_out_valid, .response_out_word,
    .host_cmd_write, .host_command_in_word, .host_resp_take, .last_taken);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Edge numbering shared with the bus tasks, which read cyc before it moves
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_rov <= resp_out_valid;
    prev_cip <= cmd_in_pending;
    if (resp_out_valid && !prev_rov) rise_cyc <= cyc;
    if (!cmd_in_pending && prev_cip) fall_cyc <= cyc;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : guard

  task automatic ticks(input int k);
    repeat (k) @(posedge aclk);
  endtask : ticks

  // Ready lines stay high throughout, so bready and rready never toggle
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      guard(n);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    hs_cyc = cyc;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!s_axi_arready);
    hs_cyc = cyc;
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : axi_read

  function automatic logic [31:0] exp_state(input int i);
    logic [3:0] d;
    d = t_dma[i];
    return {16'h0000, 1'b1, d[3], d[1], d[3] | d[2], d[1] | d[0], t_tx[i] == TXF,
            t_rx[i] != 8'h00, |t_sp[i], 2'b00, t_misc[i][3:2], t_rx[i] >= 8'h04,
            t_tx[i] <= 8'h02, t_misc[i][1:0]};
  endfunction : exp_state

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, take_en} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
    {dma_busy, tx_fill_count, rx_occupancy_count, sparse_events} = 36'h0_0000_0000;
    {cell_sched_op, assigned_cell_flag, sense_input_a, sense_input_b} = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ticks(2);
    axi_read(HMSF_OFF_EXT_STATE);
    check("state_reset", rd, 32'h0000_8004);
    axi_read(HMSF_OFF_IRQ_STAT);
    check("stat_reset", rd, 32'h0000_0000);
    check("irq_reset", {31'h0, irq}, 32'h0000_0000);
    axi_write(HMSF_OFF_IRQ_MASK, 32'h0000_0003);
    i_host.send_cmd(32'hA5C3_0F96);
    ticks(2);
    check("irq_cmd", {31'h0, irq}, 32'h0000_0001);
    axi_read(HMSF_OFF_EXT_STATE);
    check("state_cmd", rd, 32'h0000_8044);
    axi_read(HMSF_OFF_MBOX_LOW);
    check("cmd_low", rd, 32'h0000_0F96);
    axi_read(HMSF_OFF_MBOX_HIGH);
    h = hs_cyc;
    check("cmd_high", rd, 32'h0000_A5C3);
    ticks(5 * IC + 2);
    check("pend_delay", fall_cyc - h, 5 * IC + 1);
    axi_read(HMSF_OFF_IRQ_STAT);
    check("stat_cmd", rd, 32'h0000_0001);
    axi_write(HMSF_OFF_IRQ_STAT, 32'h0000_0001);
    ticks(2);
    check("irq_clr", {31'h0, irq}, 32'h0000_0000);
    axi_write(HMSF_OFF_MBOX_LOW, 32'h0000_1234);
    axi_write(HMSF_OFF_MBOX_HIGH, 32'h0000_ABCD);
    h = hs_cyc;
    check("resp_early", {31'h0, resp_out_valid}, 32'h0000_0000);
    ticks(5 * IC + 2);
    check("resp_delay", rise_cyc - h, 5 * IC + 1);
    check("resp_word", response_out_word, 32'hABCD_1234);
    axi_read(HMSF_OFF_EXT_STATE);
    check("state_resp", rd, 32'h0000_8084);
    take_en <= 1'b1;
    ticks(3);
    check("host_took", last_taken, 32'hABCD_1234);
    check("resp_clear", {31'h0, resp_out_valid}, 32'h0000_0000);
    take_en <= 1'b0;
    axi_read(HMSF_OFF_IRQ_STAT);
    check("stat_take", rd, 32'h0000_0002);
    axi_write(HMSF_OFF_IRQ_MASK, 32'h0000_0001);
    ticks(2);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    axi_write(HMSF_OFF_IRQ_STAT, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      dma_busy <= hmsf_dma_busy_type'(t_dma[i]);
      tx_fill_count <= t_tx[i];
      rx_occupancy_count <= t_rx[i];
      sparse_events <= t_sp[i];
      {cell_sched_op, assigned_cell_flag, sense_input_b, sense_input_a} <= t_misc[i];
      ticks(4 * IC + 4);
      axi_read(HMSF_OFF_EXT_STATE);
      check("state_view", rd, exp_state(i));
    end
    axi_write(HMSF_OFF_EXT_STATE, 32'h0000_FFFF);
    check("ro_resp", {30'h0, rsp}, {30'h0, HMSF_RESP_SLVERR});
    axi_read(HMSF_OFF_EXT_STATE);
    check("ro_keep", rd, exp_state(3));
    axi_write(8'h20, 32'h0000_0001);
    check("unm_wr", {30'h0, rsp}, {30'h0, HMSF_RESP_SLVERR});
    axi_read(8'h20);
    check("unm_rd", rd, 32'h0000_0000);
    check("unm_rsp", {30'h0, rsp}, {30'h0, HMSF_RESP_SLVERR});
    tally_and_finish();
  end
endmodule : testbench
